// >>> common/csf_regs.vh
`ifndef CSF_REGS_VH
`define CSF_REGS_VH
// Address and data widths
`define CSF_AW 32
`define CSF_DW 32
// Beats per burst part
`define CSF_BURST_BEATS 4
// Opcode field position in an instruction word
`define CSF_OP_MSB 31
`define CSF_OP_LSB 26
// Opcode encodings
`define CSF_OP_JUMP 6'h01
`define CSF_OP_NEXT 6'h02
`define CSF_OP_MAXLEGAL 6'h20
// Reset value of status flags
`define CSF_FLAG_RST 1'h0
`endif

// >>> verilog/csf_tag_queue.v
`include "csf_regs.vh"
// Command queue with per-entry valid tags
module csf_tag_queue #(
	parameter DEPTH = 8,
	parameter IW = 3
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Fill side
	input wire wr_valid,
	output wire wr_ready,
	input wire [`CSF_DW-1:0] wr_data,
	// Drain side
	output wire rd_valid,
	input wire rd_ready,
	output reg [`CSF_DW-1:0] rd_data,
	// Invalidate all tags
	input wire flush
);
	// Storage and tags
	reg [`CSF_DW-1:0] mem_r [0:DEPTH-1];
	reg [DEPTH-1:0] tag_r;
	reg [IW-1:0] wp_r;
	reg [IW-1:0] rp_r;
	reg [IW:0] cnt_r;
	wire do_wr;
	wire do_rd;
	assign wr_ready = (cnt_r != DEPTH[IW:0]);
	assign rd_valid = (cnt_r != {(IW+1){1'b0}}) && tag_r[rp_r];
	assign do_wr = wr_valid && wr_ready && !flush;
	assign do_rd = rd_valid && rd_ready && !flush;
	// Head data
	always @* begin
		rd_data = mem_r[rp_r];
	end
	// Pointers, tags and storage
	always @(posedge clk) begin
		if (!rst_n) begin
			tag_r <= {DEPTH{1'b0}};
			wp_r <= {IW{1'b0}};
			rp_r <= {IW{1'b0}};
			cnt_r <= {(IW+1){1'b0}};
		end else if (flush) begin
			// Kill every queued entry
			tag_r <= {DEPTH{1'b0}};
			wp_r <= {IW{1'b0}};
			rp_r <= {IW{1'b0}};
			cnt_r <= {(IW+1){1'b0}};
		end else begin
			if (do_wr) begin
				mem_r[wp_r] <= wr_data;
				tag_r[wp_r] <= 1'b1;
				wp_r <= wp_r + 1'b1;
			end
			if (do_rd) begin
				tag_r[rp_r] <= 1'b0;
				rp_r <= rp_r + 1'b1;
			end
			if (do_wr && !do_rd)
				cnt_r <= cnt_r + 1'b1;
			else if (do_rd && !do_wr)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// >>> verilog/csf_fetch.v
`include "csf_regs.vh"
// Contract
// (R01) Fetch command list into command queue
// (R02) Higher master: finish part one, hold two
// (R03) After competitor done, issue held part
// (R04) Jump/next invalidates all queued tags
// (R05) Protected/unmapped fetch sets bus error flag
// (R06) Ordinary fetch raises no error flag
// (R07) Illegal encoding sets illegal opcode flag
// (R08) Software trusts fetch error only with opcode
// (R09) Resume with jump keeps address intact
module csf_fetch #(
	parameter DEPTH = 8,
	parameter IW = 3
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Sequence control
	input wire start,
	input wire [`CSF_AW-1:0] start_addr,
	output wire busy,
	// Bus master side
	output reg bus_req,
	input wire bus_gnt,
	output reg [`CSF_AW-1:0] bus_addr,
	input wire bus_rvalid,
	input wire [`CSF_DW-1:0] bus_rdata,
	input wire bus_rerr,
	input wire bus_last,
	input wire hp_req,
	// Sequencer side
	output wire instr_valid,
	input wire instr_ready,
	output wire [`CSF_DW-1:0] instr_data,
	// Status flags
	output reg bus_fetch_err_flag,
	input wire bus_fetch_err_clr,
	output reg illegal_opcode_flag,
	input wire illegal_opcode_clr
);
	// One-hot states
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_P1 = 5'h02;
	localparam [4:0] S_HOLD = 5'h04;
	localparam [4:0] S_P2 = 5'h08;
	localparam [4:0] S_WAIT = 5'h10;
	localparam [`CSF_AW-1:0] PART_BYTES = `CSF_BURST_BEATS * 4;
	// Opcode field
	function [5:0] op_of;
		input [`CSF_DW-1:0] w;
		begin
			op_of = w[`CSF_OP_MSB:`CSF_OP_LSB];
		end
	endfunction
	// Registered state
	reg [4:0] st_r;
	reg [4:0] st_nxt;
	reg [`CSF_AW-1:0] held_addr_r;
	reg hp_seen_r;
	// Beats of a part issued before a flow change are thrown away
	reg drop_r;
	reg drop_nxt;
	// Copy of the queue fill level, used to reserve room for two parts
	reg [IW:0] occ_r;
	reg [IW:0] occ_nxt;
	wire q_ready;
	wire flow_change;
	wire [`CSF_AW-1:0] tgt;
	// Beat that is written into the queue
	wire beat_ok;
	// A part is streaming, or the bus grants one at this edge
	wire in_flight;
	// Queue has room for a whole two-part fetch next cycle
	wire room_nxt;
	assign busy = !st_r[0];
	assign tgt = {instr_data[25:0], 6'h00};
	// (R04) jump or next taken by sequencer
	assign flow_change = instr_valid && instr_ready &&
		((op_of(instr_data) == `CSF_OP_JUMP) || (op_of(instr_data) == `CSF_OP_NEXT));
	// Stale beats never reach the queue
	assign beat_ok = bus_rvalid && !bus_rerr && !st_r[0] && !drop_r;
	// Grant comes while requesting and no higher master wants the bus
	assign in_flight = (bus_gnt && !bus_last) || (bus_req && !hp_req && !bus_gnt);
	// Both parts must fit, otherwise beats would be lost
	assign room_nxt = (occ_nxt + 2 * `CSF_BURST_BEATS <= DEPTH);
	// Discard state and fill level
	always @* begin
		drop_nxt = drop_r;
		occ_nxt = occ_r;
		// (R09) part already launched from the old address is dropped
		if (flow_change && !st_r[0]) begin
			drop_nxt = in_flight;
		end else if (bus_rvalid && bus_last) begin
			// Stale part has ended
			drop_nxt = 1'b0;
		end
		if (flow_change) begin
			// Queue flushed
			occ_nxt = {(IW+1){1'b0}};
		end else if (beat_ok && q_ready && !(instr_valid && instr_ready)) begin
			// Write only
			occ_nxt = occ_r + 1'b1;
		end else if (!(beat_ok && q_ready) && instr_valid && instr_ready) begin
			// Read only
			occ_nxt = occ_r - 1'b1;
		end
	end
	// (R01) queue of fetched words
	csf_tag_queue #(.DEPTH(DEPTH), .IW(IW)) u_q (
		.clk(clk),
		.rst_n(rst_n),
		.wr_valid(beat_ok),
		.wr_ready(q_ready),
		.wr_data(bus_rdata),
		.rd_valid(instr_valid),
		.rd_ready(instr_ready),
		.rd_data(instr_data),
		.flush(flow_change)
	);
	// Next state
	always @* begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE: if (start) st_nxt = S_WAIT;
			// Grant only follows a request made with room reserved
			S_WAIT: if (bus_gnt && !drop_r) st_nxt = S_P1;
			// (R02) part one completes unless a jump or next is taken
			S_P1: if (bus_rvalid && bus_last) st_nxt = (hp_seen_r || hp_req) ? S_HOLD : S_P2;
			// (R03) resume once competitor is gone
			S_HOLD: if (bus_gnt) st_nxt = S_P2;
			S_P2: if (bus_rvalid && bus_last) st_nxt = S_WAIT;
			default: st_nxt = S_IDLE;
		endcase
		// (R04) restart a fresh two-part fetch from the target
		if (flow_change && !st_r[0]) begin
			st_nxt = S_WAIT;
		end
	end
	// Sequencing, address and flags
	always @(posedge clk) begin
		if (!rst_n) begin
			st_r <= S_IDLE;
			bus_req <= 1'b0;
			bus_addr <= {`CSF_AW{1'b0}};
			held_addr_r <= {`CSF_AW{1'b0}};
			hp_seen_r <= 1'b0;
			drop_r <= 1'b0;
			occ_r <= {(IW+1){1'b0}};
			bus_fetch_err_flag <= `CSF_FLAG_RST;
			illegal_opcode_flag <= `CSF_FLAG_RST;
		end else begin
			st_r <= st_nxt;
			drop_r <= drop_nxt;
			occ_r <= occ_nxt;
			// (R03) request kept up in hold so the bus can hand back
			bus_req <= st_nxt[1] | st_nxt[2] | st_nxt[3] | (st_nxt[4] && !drop_nxt && room_nxt);
			hp_seen_r <= st_r[1] ? (hp_seen_r | hp_req) : 1'b0;
			if (st_r[0] && start) begin
				bus_addr <= start_addr;
			end else if (flow_change) begin
				// (R09) new target replaces both live and held address
				bus_addr <= tgt;
				held_addr_r <= tgt;
			end else if (st_r[1] && st_nxt[2]) begin
				// (R02) store pending second part, also shown on the bus
				held_addr_r <= bus_addr + PART_BYTES;
				bus_addr <= bus_addr + PART_BYTES;
			end else if (st_r[2] && st_nxt[3]) begin
				// (R09) held address restored unchanged
				bus_addr <= held_addr_r;
			end else if ((st_r[1] || st_r[3]) && bus_rvalid && bus_last) begin
				bus_addr <= bus_addr + PART_BYTES;
			end
			// (R05) error only on bus error reply; (R06) none otherwise
			if (bus_rvalid && bus_rerr && !st_r[0])
				bus_fetch_err_flag <= 1'b1;
			else if (bus_fetch_err_clr)
				bus_fetch_err_flag <= 1'b0;
			// (R07) illegal opcode at queue head, separate flag
			if (instr_valid && instr_ready && op_of(instr_data) > `CSF_OP_MAXLEGAL)
				illegal_opcode_flag <= 1'b1;
			else if (illegal_opcode_clr)
				illegal_opcode_flag <= 1'b0;
		end
	end
endmodule

// >>> verification/csf_fetch_asserts.sv
`include "csf_regs.vh"
module csf_fetch_asserts (
	// Watched ports
	input wire clk, rst_n, start, busy, bus_req, bus_rvalid, bus_rerr, instr_valid,
	input wire instr_ready, bus_fetch_err_flag, bus_fetch_err_clr,
	input wire illegal_opcode_flag, illegal_opcode_clr,
	input wire [31:0] start_addr, bus_addr, instr_data
);
	// Target of the offered word
	logic [31:0] tgt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Jump or next taken
	sequence s_jump;
		instr_valid && instr_ready && instr_data[31:26] inside {`CSF_OP_JUMP, `CSF_OP_NEXT};
	endsequence
	// Start seen while idle
	sequence s_go;
		start && !busy;
	endsequence
	always @(posedge clk) tgt_r <= {instr_data[25:0], 6'h00};
	a_start_req: assert property (s_go |=> bus_req && bus_addr == $past(start_addr))
		else $error("start");
	a_busy_run: assert property (s_go |=> busy [*4]) else $error("busy");
	a_err_set: assert property (bus_rvalid && bus_rerr && busy |=> bus_fetch_err_flag)
		else $error("set");
	a_err_hold: assert property ($fell(bus_fetch_err_flag) |-> $past(bus_fetch_err_clr))
		else $error("hold");
	a_err_quiet: assert property ($rose(bus_fetch_err_flag) |-> $past(bus_rerr))
		else $error("quiet");
	a_ill_hold: assert property ($fell(illegal_opcode_flag) |-> $past(illegal_opcode_clr))
		else $error("ill");
	a_jump_flush: assert property (s_jump |=> !instr_valid) else $error("flush");
	a_jump_addr: assert property (s_jump |=> bus_addr == tgt_r) else $error("target");
endmodule
bind csf_fetch csf_fetch_asserts csf_fetch_asserts_i (.*);

// >>> verification/csf_bus_model.sv
`include "csf_regs.vh"
module csf_bus_model (
	input wire clk, rst_n, bus_req, hp_want,
	input wire [31:0] bus_addr,
	output logic bus_gnt, bus_rvalid, bus_rerr, bus_last, hp_req,
	output logic [31:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] n_r = 0;
	logic [31:0] a_r = 0;
	logic ph_r = 0;
	// Jump at page end, bad opcode at C0
	function automatic logic [31:0] word(input logic [31:0] a);
		return a[7:2] == 6'h3F ? {`CSF_OP_JUMP, 26'h2} : {a[7:2] == 6'h30 ? 6'h3F : 6'h00, a[25:0]};
	endfunction
	always @(posedge clk) begin
		ph_r <= !ph_r;
		hp_req <= hp_want;
		n_r <= (!rst_n || n_r == 4) ? 3'h0 : n_r + 3'(n_r != 0 || bus_req && !hp_req);
		a_r <= n_r != 0 ? a_r + 32'h4 : bus_addr;
	end
	assign bus_gnt = n_r != 0;
	assign bus_rvalid = bus_gnt;
	assign bus_last = n_r == 4;
	assign bus_rerr = bus_gnt && a_r[31];
	assign bus_rdata = bus_gnt ? word(a_r) : {32{ph_r}};
endmodule

// >>> verification/csf_fetch_tb_top.sv
`include "csf_regs.vh"
module csf_fetch_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, start = 0, instr_ready = 0, hp_want = 0;
	logic bus_fetch_err_clr = 0, illegal_opcode_clr = 0;
	logic [31:0] start_addr = 0, pc_r = 0, e_r, seed = 32'h410C, exp_q[$];
	int fail_count = 0, n_tests = 0, cyc = 0;
	wire bus_req, bus_gnt, bus_rvalid, bus_rerr, bus_last, hp_req, busy, instr_valid;
	wire bus_fetch_err_flag, illegal_opcode_flag;
	wire [31:0] bus_addr, bus_rdata, instr_data;
	csf_fetch csf_fetch_i (.*);
	csf_bus_model csf_bus_model_i (.*);
	initial forever #2 clk = !clk;
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string s, logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic stop_test;
		$display("%0d checks, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Release reset, start, note first word
	task automatic go(logic [31:0] a);
		rst_n = 1;
		pc_r = a;
		exp_q = {a[31] ? 32'hX : csf_bus_model_i.word(a)};
		start_addr = a;
		start = 1;
		step(1);
		start = 0;
	endtask
	// Compare each taken word, note the next
	always @(posedge clk) if (rst_n && instr_valid && instr_ready) begin
		e_r = exp_q.pop_front();
		chk("instr", e_r, instr_data);
		pc_r = e_r[31:26] inside {`CSF_OP_JUMP, `CSF_OP_NEXT} ? {e_r[25:0], 6'h00} : pc_r + 4;
		exp_q.push_back(pc_r[31] ? 32'hX : csf_bus_model_i.word(pc_r));
	end
	// Random ready and competitor, watchdog
	always @(posedge clk) begin
		#1;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		instr_ready = seed[0];
		hp_want = seed[3:1] == 0;
		if (++cyc > 2000) begin
			fail_count++;
			stop_test;
		end
	end
	initial begin
		step(5);
		go(0);
		step(600);
		chk("fetch error", 0, bus_fetch_err_flag);
		chk("illegal", 1, illegal_opcode_flag);
		$display("test fetch done");
		rst_n = 0;
		step(5);
		go(32'hF000_0000);
		step(100);
		chk("fetch error", 1, bus_fetch_err_flag);
		chk("isolated error", 0, illegal_opcode_flag);
		$display("test error done");
		stop_test;
	end
endmodule
